// ===== core/csirb_pkg.sv
// Shared constants of the colour sensor register bank and its I2C host.
// Assumes a single 10 MHz system clock on both ends.
package csirb_pkg;
	// Target address and command codes
	localparam logic [6:0] DEV_ADDR = 7'h10;
	localparam logic [7:0] CMD_CFG = 8'h00;
	localparam logic [7:0] CMD_CLEAR = 8'h04;
	localparam logic [7:0] CMD_RED = 8'h05;
	localparam logic [7:0] CMD_GREEN = 8'h06;
	localparam logic [7:0] CMD_BLUE = 8'h07;
	localparam logic [7:0] CMD_IR = 8'h08;
	localparam logic [7:0] CMD_ID = 8'h0C;
	// Configuration word fields
	localparam int SHUTDOWN_HIGH_BIT = 15;
	localparam int REDUCED_POWER_BIT = 14;
	localparam int DGAIN_LSB = 12;
	localparam int AGAIN_LSB = 10;
	localparam int SENSITIVITY_BIT = 6;
	localparam int ITIME_LSB = 4;
	localparam int FORCED_BIT = 3;
	localparam int MEASURE_REQ_BIT = 2;
	localparam int SHUTDOWN_LOW_BIT = 0;
	localparam logic [15:0] CFG_RESET = 16'h8001;
	localparam logic [15:0] CFG_WMASK = 16'hFC7D;
	localparam logic [7:0] ID_HIGH_RESERVED = 8'h00;
	localparam int NUM_CH = 5;
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int INT_BASE_MS = 50;
	localparam int INT_BASE_CYC = CLK_HZ / 1000 * INT_BASE_MS;
	localparam int SCL_KHZ = 100;
	localparam int SCL_QTR_CYC = CLK_HZ / (SCL_KHZ * 1000 * 4);
	// Host APB registers
	localparam logic [7:0] HOST_CTRL = 8'h00;
	localparam logic [7:0] HOST_WDATA = 8'h04;
	localparam logic [7:0] HOST_RDATA = 8'h08;
	localparam logic [7:0] HOST_STATUS = 8'h0C;
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_READ_BIT = 1;
	localparam int CTRL_CMD_LSB = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_NACK_BIT = 1;
	localparam int STAT_REFUSED_BIT = 2;

	function automatic logic is_reserved_cmd(input logic [7:0] cmd);
		return (cmd >= 8'h01 && cmd <= 8'h03) || (cmd >= 8'h09 && cmd <= 8'h0B);
	endfunction : is_reserved_cmd
endpackage : csirb_pkg

// ===== core/csirb_i2c_if.sv
// Open-drain I2C wires between host and sensor.
// Assumes pull-ups: a line is low only while some party enables a low drive.
interface csirb_i2c_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
		output host_sda_oe, input scl, input sda);
	modport device (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface : csirb_i2c_if

// ===== core/csirb_sync3.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous pin input; output idles high like the bus.
module csirb_sync3 (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Pin and filtered level
	input wire logic pin,
	output logic level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A change is taken only once stages two and three agree
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			level <= 1'b1;
		end else if (s2_r == s3_r) begin
			level <= s3_r;
		end
	end
endmodule : csirb_sync3

// ===== core/csirb_device.sv
// Colour sensor target: I2C command decoder, register bank, measurement timer.
// Assumes raw channel counts from the front end on raw_counts, same clock.
//
module csirb_device #(
	parameter int unsigned INT_BASE_CYC = csirb_pkg::INT_BASE_CYC,
	parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary identity value
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// I2C bus
	csirb_i2c_if.device bus,
	// Front end counts, channel c at bits 16c+15:16c
	input wire logic [79:0] raw_counts,
	// Front end settings
	output logic sensor_powered,
	output logic red_blue_powered,
	output logic [1:0] analog_gain,
	output logic low_sensitivity,
	output logic [1:0] integration_select,
	// Measurement status
	output logic meas_busy,
	output logic sample_strobe
);
	typedef enum logic [4:0] {
		D_IDLE = 5'b00001,
		D_RX = 5'b00010,
		D_ACK = 5'b00100,
		D_TX = 5'b01000,
		D_RACK = 5'b10000
	} csirb_dev_state_t;

	csirb_dev_state_t st_r;
	logic scl_q;
	logic sda_q;
	logic scl_d_r;
	logic sda_d_r;
	logic rise;
	logic fall;
	logic start_ev;
	logic stop_ev;
	logic [3:0] cnt_r;
	logic [2:0] idx_r;
	logic rd_r;
	logic [7:0] sh_r;
	logic [7:0] cmd_r;
	logic [7:0] wlo_r;
	logic [15:0] txw_r;
	logic tx_hi_r;
	logic [7:0] txs_r;
	logic wr_r;
	logic [15:0] cfg_r;
	logic [15:0] rd_word;
	logic [15:0] result_r [csirb_pkg::NUM_CH];
	logic [31:0] meas_cnt_r;
	logic [31:0] period;
	logic meas_go;
	logic meas_done;

	csirb_sync3 u_scl (.clk(clk), .reset(reset), .pin(bus.scl), .level(scl_q));
	csirb_sync3 u_sda (.clk(clk), .reset(reset), .pin(bus.sda), .level(sda_q));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_q;
			sda_d_r <= sda_q;
		end
	end

	assign rise = scl_q & ~scl_d_r;
	assign fall = ~scl_q & scl_d_r;
	assign start_ev = scl_q & scl_d_r & sda_d_r & ~sda_q;
	assign stop_ev = scl_q & scl_d_r & ~sda_d_r & sda_q;

	// Byte-level protocol engine
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_r <= D_IDLE;
			cnt_r <= 4'h0;
			idx_r <= 3'h0;
			rd_r <= 1'b0;
			sh_r <= 8'h00;
			cmd_r <= 8'h00;
			wlo_r <= 8'h00;
			txw_r <= 16'h0000;
			tx_hi_r <= 1'b0;
			txs_r <= 8'h00;
			wr_r <= 1'b0;
		end else begin
			wr_r <= 1'b0;
			if (start_ev) begin
				st_r <= D_RX;
				cnt_r <= 4'h0;
				idx_r <= 3'h0;
			end else if (stop_ev) begin
				st_r <= D_IDLE;
			end else begin
				case (st_r)
					D_RX: begin
						if (rise) begin
							sh_r <= {sh_r[6:0], sda_q};
							cnt_r <= cnt_r + 4'h1;
						end else if (fall && cnt_r == 4'h8) begin
							if (idx_r == 3'h0) begin
								if (sh_r[7:1] == csirb_pkg::DEV_ADDR) begin
									st_r <= D_ACK;
									rd_r <= sh_r[0];
								end else begin
									st_r <= D_IDLE;
								end
							end else if (idx_r <= 3'h3) begin
								st_r <= D_ACK;
							end else begin
								st_r <= D_IDLE;
							end
							if (idx_r == 3'h1) begin
								cmd_r <= sh_r;
							end
							if (idx_r == 3'h2) begin
								wlo_r <= sh_r;
							end
							wr_r <= (idx_r == 3'h3);
						end
					end
					D_ACK: begin
						if (fall) begin
							cnt_r <= 4'h0;
							if (rd_r) begin
								st_r <= D_TX;
								txw_r <= rd_word;
								txs_r <= rd_word[7:0];
								tx_hi_r <= 1'b1;
							end else begin
								st_r <= D_RX;
								idx_r <= idx_r + 3'h1;
							end
						end
					end
					D_TX: begin
						if (fall) begin
							if (cnt_r == 4'h7) begin
								st_r <= D_RACK;
							end else begin
								txs_r <= {txs_r[6:0], 1'b0};
								cnt_r <= cnt_r + 4'h1;
							end
						end
					end
					D_RACK: begin
						if (rise && sda_q) begin
							st_r <= D_IDLE;
						end else if (fall) begin
							st_r <= D_TX;
							cnt_r <= 4'h0;
							txs_r <= tx_hi_r ? txw_r[15:8] : txw_r[7:0];
							tx_hi_r <= ~tx_hi_r;
						end
					end
					default: st_r <= D_IDLE;
				endcase
			end
		end
	end

	// Open-drain data drive, low only
	assign bus.dev_sda_o = 1'b0;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bus.dev_sda_oe <= 1'b0;
		end else begin
			bus.dev_sda_oe <= (st_r == D_ACK) || (st_r == D_TX && !txs_r[7]);
		end
	end

	// Read word selection
	always_comb begin
		case (cmd_r)
			csirb_pkg::CMD_CFG: rd_word = cfg_r;
			csirb_pkg::CMD_CLEAR: rd_word = result_r[0];
			csirb_pkg::CMD_RED: rd_word = result_r[1];
			csirb_pkg::CMD_GREEN: rd_word = result_r[2];
			csirb_pkg::CMD_BLUE: rd_word = result_r[3];
			csirb_pkg::CMD_IR: rd_word = result_r[4];
			csirb_pkg::CMD_ID: rd_word = {csirb_pkg::ID_HIGH_RESERVED, ID_CODE};
			default: rd_word = 16'h0000;
		endcase
	end

	// Configuration word; a host write beats the trigger self-clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_r <= csirb_pkg::CFG_RESET;
		end else if (wr_r && cmd_r == csirb_pkg::CMD_CFG) begin
			cfg_r <= {sh_r, wlo_r} & csirb_pkg::CFG_WMASK;
		end else if (meas_done && cfg_r[csirb_pkg::FORCED_BIT]) begin
			cfg_r[csirb_pkg::MEASURE_REQ_BIT] <= 1'b0;
		end
	end

	assign sensor_powered = ~cfg_r[csirb_pkg::SHUTDOWN_HIGH_BIT]
		& ~cfg_r[csirb_pkg::SHUTDOWN_LOW_BIT];
	assign red_blue_powered = sensor_powered & ~cfg_r[csirb_pkg::REDUCED_POWER_BIT];
	assign analog_gain = cfg_r[csirb_pkg::AGAIN_LSB +: 2];
	assign low_sensitivity = cfg_r[csirb_pkg::SENSITIVITY_BIT];
	assign integration_select = cfg_r[csirb_pkg::ITIME_LSB +: 2];

	// Measurement timer
	assign period = INT_BASE_CYC << cfg_r[csirb_pkg::ITIME_LSB +: 2];
	assign meas_go = sensor_powered
		& (~cfg_r[csirb_pkg::FORCED_BIT] | cfg_r[csirb_pkg::MEASURE_REQ_BIT]);
	assign meas_done = meas_go && (meas_cnt_r >= period - 32'h1);
	assign meas_busy = meas_go;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meas_cnt_r <= 32'h0;
		end else if (!meas_go || meas_done) begin
			meas_cnt_r <= 32'h0;
		end else begin
			meas_cnt_r <= meas_cnt_r + 32'h1;
		end
	end

	function automatic logic [15:0] dgain(input logic [15:0] raw, input logic [1:0] sel);
		case (sel)
			2'b01: dgain = raw[15] ? 16'hFFFF : {raw[14:0], 1'b0};
			2'b10: dgain = (|raw[15:14]) ? 16'hFFFF : {raw[13:0], 2'b00};
			default: dgain = raw;
		endcase
	endfunction : dgain

	// Results latch at the end of each integration period, red and blue only while red_blue_powered
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sample_strobe <= 1'b0;
			for (int c = 0; c < csirb_pkg::NUM_CH; c++) begin
				result_r[c] <= 16'h0000;
			end
		end else begin
			sample_strobe <= meas_done;
			for (int c = 0; c < csirb_pkg::NUM_CH; c++) begin
				if (meas_done && (red_blue_powered || (c != 1 && c != 3))) begin
					result_r[c] <= dgain(raw_counts[16*c +: 16],
						cfg_r[csirb_pkg::DGAIN_LSB +: 2]);
				end
			end
		end
	end
endmodule : csirb_device

// ===== core/csirb_host.sv
// I2C host for the colour sensor, commanded over an APB slave.
// Assumes the target never stretches the clock.
module csirb_host #(
	parameter int unsigned QTR_CYC = csirb_pkg::SCL_QTR_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// I2C bus
	csirb_i2c_if.host bus
);
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_START = 4'b0010,
		H_BYTE = 4'b0100,
		H_STOP = 4'b1000
	} csirb_host_state_t;

	csirb_host_state_t st_r;
	csirb_host_state_t st_nxt;
	logic sda_q;
	logic mapped;
	logic apb_wr;
	logic go_req;
	logic go_ok;
	logic [7:0] cmd_r;
	logic read_r;
	logic [15:0] wdata_r;
	logic [15:0] wword_r;
	logic [15:0] rdata_r;
	logic nack_r;
	logic refused_r;
	logic abort_r;
	logic [15:0] qcnt_r;
	logic [1:0] ph_r;
	logic tick;
	logic [2:0] step_r;
	logic [3:0] bit_r;
	logic [7:0] rxs_r;
	logic [7:0] tx_byte;
	logic is_rx;
	logic give_ack;
	logic sda_val;

	csirb_sync3 u_sda (.clk(clk), .reset(reset), .pin(bus.sda), .level(sda_q));

	assign mapped = paddr == csirb_pkg::HOST_CTRL || paddr == csirb_pkg::HOST_WDATA
		|| paddr == csirb_pkg::HOST_RDATA || paddr == csirb_pkg::HOST_STATUS;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign apb_wr = psel & penable & pwrite & mapped;
	assign go_req = apb_wr && paddr == csirb_pkg::HOST_CTRL && pwdata[csirb_pkg::CTRL_GO_BIT]
		&& st_r == H_IDLE;
	assign go_ok = go_req && !csirb_pkg::is_reserved_cmd(pwdata[csirb_pkg::CTRL_CMD_LSB +: 8]);

	// Software registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmd_r <= 8'h00;
			read_r <= 1'b0;
			wdata_r <= 16'h0000;
			wword_r <= 16'h0000;
			refused_r <= 1'b0;
		end else begin
			if (apb_wr && paddr == csirb_pkg::HOST_WDATA) begin
				wdata_r <= pwdata[15:0];
			end
			if (go_req) begin
				refused_r <= !go_ok;
			end
			if (go_ok) begin
				cmd_r <= pwdata[csirb_pkg::CTRL_CMD_LSB +: 8];
				read_r <= pwdata[csirb_pkg::CTRL_READ_BIT];
				if (pwdata[csirb_pkg::CTRL_CMD_LSB +: 8] == csirb_pkg::CMD_CFG) begin
					wword_r <= {wdata_r[csirb_pkg::SHUTDOWN_LOW_BIT], wdata_r[14:0]}
						& csirb_pkg::CFG_WMASK;
				end else begin
					wword_r <= wdata_r;
				end
			end
		end
	end

	// Read data is prepared in the setup cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			case (paddr)
				csirb_pkg::HOST_CTRL: prdata <= {16'h0, cmd_r, 6'h0, read_r, 1'b0};
				csirb_pkg::HOST_WDATA: prdata <= {16'h0, wdata_r};
				csirb_pkg::HOST_RDATA: prdata <= {16'h0, rdata_r};
				csirb_pkg::HOST_STATUS: prdata <= {29'h0, refused_r, nack_r, st_r != H_IDLE};
				default: prdata <= 32'h0;
			endcase
		end
	end

	// Byte sequence of a transfer
	always_comb begin
		tx_byte = 8'h00;
		is_rx = 1'b0;
		give_ack = 1'b0;
		case (step_r)
			3'd1: tx_byte = {csirb_pkg::DEV_ADDR, 1'b0};
			3'd2: tx_byte = cmd_r;
			3'd3: tx_byte = wword_r[7:0];
			3'd4: tx_byte = read_r ? {csirb_pkg::DEV_ADDR, 1'b1} : wword_r[15:8];
			3'd5: begin
				is_rx = 1'b1;
				give_ack = 1'b1;
			end
			3'd6: is_rx = 1'b1;
			default: tx_byte = 8'h00;
		endcase
		if (read_r) begin
			st_nxt = (step_r == 3'd2) ? H_START : (step_r == 3'd6) ? H_STOP : H_BYTE;
		end else begin
			st_nxt = (step_r == 3'd4) ? H_STOP : H_BYTE;
		end
		if (bit_r[3]) begin
			sda_val = is_rx ? !give_ack : 1'b1;
		end else begin
			sda_val = is_rx ? 1'b1 : tx_byte[3'd7 - bit_r[2:0]];
		end
	end

	assign tick = qcnt_r == 16'(QTR_CYC - 1);
	assign bus.host_scl_o = 1'b0;
	assign bus.host_sda_o = 1'b0;

	// Bit engine, four quarter phases per SCL period
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_r <= H_IDLE;
			qcnt_r <= 16'h0;
			ph_r <= 2'd0;
			step_r <= 3'd0;
			bit_r <= 4'h0;
			rxs_r <= 8'h00;
			rdata_r <= 16'h0000;
			nack_r <= 1'b0;
			abort_r <= 1'b0;
			bus.host_scl_oe <= 1'b0;
			bus.host_sda_oe <= 1'b0;
		end else if (st_r == H_IDLE) begin
			qcnt_r <= 16'h0;
			ph_r <= 2'd0;
			if (go_ok) begin
				st_r <= H_START;
				step_r <= 3'd0;
				bit_r <= 4'h0;
				nack_r <= 1'b0;
				abort_r <= 1'b0;
			end
		end else begin
			qcnt_r <= tick ? 16'h0 : qcnt_r + 16'h1;
			if (tick) begin
				ph_r <= ph_r + 2'd1;
				case (st_r)
					H_START: begin
						case (ph_r)
							2'd0: bus.host_sda_oe <= 1'b0;
							2'd1: bus.host_scl_oe <= 1'b0;
							2'd2: bus.host_sda_oe <= 1'b1;
							default: begin
								bus.host_scl_oe <= 1'b1;
								st_r <= H_BYTE;
								step_r <= step_r + 3'd1;
							end
						endcase
					end
					H_BYTE: begin
						case (ph_r)
							2'd0: bus.host_sda_oe <= !sda_val;
							2'd1: bus.host_scl_oe <= 1'b0;
							2'd2: begin
								if (!bit_r[3] && is_rx) begin
									rxs_r <= {rxs_r[6:0], sda_q};
								end
								if (bit_r[3] && !is_rx && sda_q) begin
									nack_r <= 1'b1;
									abort_r <= 1'b1;
								end
							end
							default: begin
								bus.host_scl_oe <= 1'b1;
								if (!bit_r[3]) begin
									bit_r <= bit_r + 4'h1;
								end else begin
									bit_r <= 4'h0;
									step_r <= step_r + 3'd1;
									st_r <= abort_r ? H_STOP : st_nxt;
									if (is_rx && give_ack) begin
										rdata_r[7:0] <= rxs_r;
									end
									if (is_rx && !give_ack) begin
										rdata_r[15:8] <= rxs_r;
									end
								end
							end
						endcase
					end
					H_STOP: begin
						case (ph_r)
							2'd0: bus.host_sda_oe <= 1'b1;
							2'd1: bus.host_scl_oe <= 1'b0;
							2'd2: bus.host_sda_oe <= 1'b0;
							default: st_r <= H_IDLE;
						endcase
					end
					default: st_r <= H_IDLE;
				endcase
			end
		end
	end
endmodule : csirb_host

// ===== dv/csirb_sva.sv
// Checker on the I2C wires between host and sensor, plus sensor outputs.
// Assumes tb_top instantiates it beside the interface; one clock domain.
module csirb_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// I2C wires
	input wire logic host_scl_o,
	input wire logic host_sda_o,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda,
	// Sensor outputs
	input wire logic sensor_powered,
	input wire logic red_blue_powered,
	input wire logic meas_busy,
	input wire logic sample_strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence bus_high;
		scl && $past(scl);
	endsequence
	sequence bus_start;
		bus_high ##0 $fell(sda);
	endsequence
	sequence bus_stop;
		bus_high ##0 $rose(sda);
	endsequence

	AST_OPEN_DRAIN: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
		else $error("open-drain output drives high");
	AST_START_HOLD: assert property (bus_start |-> scl [*6])
		else $error("clock not held high after start");
	AST_STOP_RELEASE: assert property (bus_stop |-> !dev_sda_oe)
		else $error("sensor drives data at stop");
	AST_DATA_STABLE: assert property (bus_high |-> dev_sda_oe == $past(dev_sda_oe))
		else $error("sensor changed data while clock high");
	AST_RB_NEEDS_POWER: assert property (red_blue_powered |-> sensor_powered)
		else $error("red and blue powered during shutdown");
	AST_OFF_IDLE: assert property (!sensor_powered && !$past(sensor_powered) |-> !meas_busy)
		else $error("measuring while shut down");
	AST_STROBE_GAP: assert property (sample_strobe |=> !sample_strobe [*8])
		else $error("result strobes too close");
	AST_STROBE_CAUSE: assert property (sample_strobe |-> $past(meas_busy))
		else $error("result strobe without measurement");
endmodule : csirb_sva

// ===== dv/tb_top.sv
// Bench for the colour sensor host and target joined over I2C.
// Assumes the core files are compiled first; one 10 MHz clock.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
	localparam logic [7:0] ID = 8'hA5; // Arbitrary identity value
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err;
	logic [79:0] raw_counts = 80'h0;
	logic [79:0] keep;
	logic sensor_powered, red_blue_powered, low_sensitivity, meas_busy, sample_strobe;
	logic [1:0] analog_gain, integration_select;
	logic [15:0] cfg;
	logic [7:0] last2;
	logic [32:0] expq[$];
	logic [7:0] rsv[6] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0A, 8'h0B};
	int mismatches = 0;
	int check_count = 0;
	int strobes = 0;
	int n, base;

	csirb_i2c_if i2c ();
	csirb_host #(.QTR_CYC(8)) i_csirb_host (.clk, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .bus(i2c));
	csirb_device #(.INT_BASE_CYC(20), .ID_CODE(ID)) i_csirb_device (.clk, .reset, .bus(i2c),
		.raw_counts, .sensor_powered, .red_blue_powered, .analog_gain, .low_sensitivity,
		.integration_select, .meas_busy, .sample_strobe);
	csirb_sva i_csirb_sva (.clk, .reset, .host_scl_o(i2c.host_scl_o),
		.host_sda_o(i2c.host_sda_o), .dev_sda_o(i2c.dev_sda_o), .dev_sda_oe(i2c.dev_sda_oe),
		.scl(i2c.scl), .sda(i2c.sda), .sensor_powered, .red_blue_powered, .meas_busy,
		.sample_strobe);

	initial begin
		forever #50 clk = ~clk;
	end

	// Read results are compared against the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite && expq.size() > 0) begin
			if (expq[0][32])
				`CHK("apb read", expq[0][31:0], prdata)
			void'(expq.pop_front());
		end
		if (sample_strobe === 1'b1)
			strobes++;
	end

	// First byte after every start carries the target address
	initial forever begin : wire_mon
		logic [7:0] b;
		@(negedge i2c.sda iff i2c.scl === 1'b1);
		repeat (8) begin
			@(posedge i2c.scl);
			b = {b[6:0], i2c.sda};
		end
		`CHK("address", csirb_pkg::DEV_ADDR, b[7:1])
		repeat (9) begin
			@(posedge i2c.scl);
			b = {b[6:0], i2c.sda};
		end
		last2 = b;
	end

	function automatic logic [15:0] sat(input logic [15:0] v, input int g);
		logic [17:0] p;
		p = (g == 1) ? {1'b0, v, 1'b0} : (g == 2) ? {v, 2'b0} : {2'b0, v};
		return (p > 18'h0FFFF) ? 16'hFFFF : p[15:0];
	endfunction : sat

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic chk, input logic [31:0] e);
		int k;
		k = 0;
		if (!wr)
			expq.push_back({chk, e});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++k < 50);
		if (pready !== 1'b1)
			mismatches++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic op(input logic rdop, input logic [7:0] cmd, input logic [15:0] d,
		input logic [15:0] e);
		int k;
		k = 0;
		apb(1'b1, csirb_pkg::HOST_WDATA, {16'h0, d}, 1'b0, 32'h0);
		apb(1'b1, csirb_pkg::HOST_CTRL, {16'h0, cmd, 6'h0, rdop, 1'b1}, 1'b0, 32'h0);
		do begin
			apb(1'b0, csirb_pkg::HOST_STATUS, 32'h0, 1'b0, 32'h0);
			k++;
		end while (rd[0] !== 1'b0 && k < 2000);
		if (rd[0] !== 1'b0)
			mismatches++;
		`CHK("nack", 1'b0, rd[1])
		if (rdop)
			apb(1'b0, csirb_pkg::HOST_RDATA, 32'h0, 1'b1, {16'h0, e});
	endtask : op

	task automatic wstrobe(output int c);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (sample_strobe !== 1'b1 && c < 5000);
		if (sample_strobe !== 1'b1)
			mismatches++;
	endtask : wstrobe

	task automatic summarize();
		if (mismatches == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	initial begin
		#9_000_000;
		mismatches++;
		summarize();
	end

	initial begin
		void'($urandom(54216));
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK("scl idle", 1'b1, i2c.scl)
		op(1'b1, 8'h00, 16'h0, 16'h8001);
		`CHK("powered", 1'b0, sensor_powered)
		op(1'b0, 8'h00, 16'h0000, 16'h0);
		`CHK("powered", 1'b1, sensor_powered)
		`CHK("busy", 1'b1, meas_busy)
		for (int i = 0; i < 2; i++) begin
			cfg = 16'($urandom()) & 16'h7FF2;
			op(1'b0, 8'h00, cfg, 16'h0);
			op(1'b1, 8'h00, 16'h0, cfg & 16'hFC7D);
			`CHK("red blue", !cfg[14], red_blue_powered)
			`CHK("analog gain", cfg[11:10], analog_gain)
			`CHK("sensitivity", cfg[6], low_sensitivity)
			`CHK("itime", cfg[5:4], integration_select)
		end
		for (int g = 0; g < 4; g++) begin
			raw_counts <= {$urandom(), $urandom(), 16'($urandom())};
			op(1'b0, 8'h00, 16'((g << 12) | (g << 4)), 16'h0);
			wstrobe(n);
			wstrobe(n);
			`CHK("period", 20 << g, n)
			for (int c = 0; c < 5; c++)
				op(1'b1, 8'(4 + c), 16'h0, sat(raw_counts[16*c +: 16], g));
		end
		keep = raw_counts;
		op(1'b0, 8'h00, 16'h4000, 16'h0);
		raw_counts <= ~keep;
		wstrobe(n);
		wstrobe(n);
		op(1'b1, csirb_pkg::CMD_BLUE, 16'h0, keep[63:48]);
		op(1'b1, csirb_pkg::CMD_GREEN, 16'h0, ~keep[47:32]);
		op(1'b1, csirb_pkg::CMD_ID, 16'h0, {8'h00, ID});
		`CHK("low byte first", ID, last2)
		foreach (rsv[k]) begin
			apb(1'b1, csirb_pkg::HOST_CTRL, {16'h0, rsv[k], 8'h01}, 1'b0, 32'h0);
			apb(1'b0, csirb_pkg::HOST_STATUS, 32'h4 & 32'h0, 1'b1, 32'h4);
			`CHK("no slave error", 1'b0, err)
		end
		apb(1'b1, 8'h10, 32'hFFFF_FFFF, 1'b0, 32'h0);
		`CHK("write slave error", 1'b1, err)
		apb(1'b0, 8'h10, 32'h0, 1'b1, 32'h0);
		`CHK("read slave error", 1'b1, err)
		op(1'b0, 8'h00, 16'h0008, 16'h0);
		`CHK("forced idle", 1'b0, meas_busy)
		base = strobes;
		op(1'b0, 8'h00, 16'h000C, 16'h0);
		op(1'b1, 8'h00, 16'h0, 16'h0008);
		`CHK("one measurement", 1, strobes - base)
		op(1'b0, 8'h00, 16'h8001, 16'h0);
		`CHK("shutdown", 1'b0, sensor_powered)
		`CHK("shutdown busy", 1'b0, meas_busy)
		`CHK("notes drained", 0, expq.size())
		summarize();
	end
endmodule : tb_top
